// [rtl/cias_status_bank.sv]
// Status and configuration register bank for the input clock alarms
`timescale 1ns/1ps
`default_nettype none
module cias_status_bank #(
	parameter int DIV_W = 8
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire cias_pkg::cias_req_t req,
	input wire cias_pkg::cias_status_t status_raw,
	input wire logic in2_selected,
	output logic [7:0] rdata,
	output logic rvalid,
	output logic [DIV_W-1:0] second_input_divider_low,
	output logic [2:0] in1_band_select,
	output logic [2:0] in2_band_select,
	output logic in1_active_indicator,
	output logic in2_active_indicator,
	output logic hold_spec_unreliable
);
	import cias_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Alarm synchronisers; selection travels with the alarms
	logic [CIAS_STATUS_W:0] sync_out;
	cias_status_t st;
	logic sel2_s;

	cias_sync #(
		.WIDTH(CIAS_STATUS_W + 1)
	) u_sync (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.d({in2_selected, status_raw}),
		.q(sync_out)
	);

	// Split synchronised vector back into fields
	always_comb begin
		st = cias_status_t'(sync_out[CIAS_STATUS_W-1:0]);
		sel2_s = sync_out[CIAS_STATUS_W];
	end

	////////////////////////////////////////////////////////////////////////
	// Decode of one access
	logic wr_div;
	logic wr_band;
	logic wr_abs_stk;
	logic wr_ofs_stk;

	always_comb begin
		wr_div = req.wr && (req.addr == CIAS_OFF_IN2_DIV_LOW);
		wr_band = req.wr && (req.addr == CIAS_OFF_BAND_SEL);
		wr_abs_stk = req.wr && (req.addr == CIAS_OFF_ABSENT_STICKY);
		wr_ofs_stk = req.wr && (req.addr == CIAS_OFF_OFS_LOCK_STICKY);
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration registers
	logic [DIV_W-1:0] div_next;
	logic [2:0] band1_next;
	logic [2:0] band2_next;
	logic [2:0] wband1;
	logic [2:0] wband2;

	// Reserved band codes are refused so the monitor never sees them
	always_comb begin
		wband1 = req.wdata[CIAS_BAND1_LSB +: CIAS_BAND_W];
		wband2 = req.wdata[CIAS_BAND2_LSB +: CIAS_BAND_W];
		div_next = second_input_divider_low;
		band1_next = in1_band_select;
		band2_next = in2_band_select;
		if (wr_div) begin
			div_next = req.wdata[DIV_W-1:0];
		end
		if (wr_band && wband1 <= CIAS_BAND_HIGHEST) begin
			band1_next = wband1;
		end
		if (wr_band && wband2 <= CIAS_BAND_HIGHEST) begin
			band2_next = wband2;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			second_input_divider_low <= CIAS_RST_IN2_DIV_LOW[DIV_W-1:0];
			in1_band_select <= CIAS_RST_BAND;
			in2_band_select <= CIAS_RST_BAND;
		end else begin
			second_input_divider_low <= div_next;
			in1_band_select <= band1_next;
			in2_band_select <= band2_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Active input indicators; a lost input is never shown active
	logic act1_next;
	logic act2_next;
	logic unrel_next;

	always_comb begin
		act1_next = !sel2_s && !st.in1_absent;
		act2_next = sel2_s && !st.in2_absent;
		unrel_next = !st.hold_valid;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			in1_active_indicator <= 1'b0;
			in2_active_indicator <= 1'b0;
			hold_spec_unreliable <= 1'b1;
		end else begin
			in1_active_indicator <= act1_next;
			in2_active_indicator <= act2_next;
			hold_spec_unreliable <= unrel_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sticky flags: an alarm in the clearing cycle keeps its flag set
	logic [2:0] abs_stk_reg;
	logic [2:0] abs_stk_next;
	logic [2:0] ofs_stk_reg;
	logic [2:0] ofs_stk_next;
	logic [2:0] abs_live;
	logic [2:0] ofs_live;

	always_comb begin
		abs_live = {st.in2_absent, st.in1_absent, st.ref_absent};
		ofs_live = {st.in2_offset, st.in1_offset, st.unlocked};
		abs_stk_next = abs_stk_reg;
		ofs_stk_next = ofs_stk_reg;
		if (wr_abs_stk) begin
			abs_stk_next = abs_stk_reg & req.wdata[CIAS_BIT_IN2_ABSENT:0];
		end
		if (wr_ofs_stk) begin
			ofs_stk_next = ofs_stk_reg &
				req.wdata[CIAS_BIT_IN2_OFFSET_STK:CIAS_BIT_UNLOCKED_STK];
		end
		abs_stk_next = abs_stk_next | abs_live;
		ofs_stk_next = ofs_stk_next | ofs_live;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			abs_stk_reg <= 3'h0;
			ofs_stk_reg <= 3'h0;
		end else begin
			abs_stk_reg <= abs_stk_next;
			ofs_stk_reg <= ofs_stk_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path; unmapped offsets read zero, one cycle after the strobe
	logic [7:0] rdata_next;

	always_comb begin
		rdata_next = CIAS_ZERO_BYTE;
		case (req.addr)
			CIAS_OFF_IN2_DIV_LOW: begin
				rdata_next[DIV_W-1:0] = second_input_divider_low;
			end
			CIAS_OFF_BAND_SEL: begin
				rdata_next[CIAS_BAND1_LSB +: CIAS_BAND_W] = in1_band_select;
				rdata_next[CIAS_BAND2_LSB +: CIAS_BAND_W] = in2_band_select;
			end
			CIAS_OFF_ACTIVE_IND: begin
				rdata_next = CIAS_RST_ACTIVE_IND;
				rdata_next[CIAS_BIT_IN1_ACTIVE] = in1_active_indicator;
				rdata_next[CIAS_BIT_IN2_ACTIVE] = in2_active_indicator;
			end
			CIAS_OFF_ABSENT_STAT: begin
				rdata_next[CIAS_BIT_IN2_ABSENT] = st.in2_absent;
				rdata_next[CIAS_BIT_IN1_ABSENT] = st.in1_absent;
				rdata_next[CIAS_BIT_REF_ABSENT] = st.ref_absent;
			end
			CIAS_OFF_OFS_LOCK_STAT: begin
				rdata_next[CIAS_BIT_HOLD_VALID] = st.hold_valid;
				rdata_next[CIAS_BIT_IN2_OFFSET] = st.in2_offset;
				rdata_next[CIAS_BIT_IN1_OFFSET] = st.in1_offset;
				rdata_next[CIAS_BIT_UNLOCKED] = st.unlocked;
			end
			CIAS_OFF_ABSENT_STICKY: begin
				rdata_next[CIAS_BIT_IN2_ABSENT:0] = abs_stk_reg;
			end
			CIAS_OFF_OFS_LOCK_STICKY: begin
				rdata_next[CIAS_BIT_IN2_OFFSET_STK:CIAS_BIT_UNLOCKED_STK] =
					ofs_stk_reg;
			end
			default: begin
				rdata_next = CIAS_ZERO_BYTE;
			end
		endcase
		if (!req.rd) begin
			rdata_next = CIAS_ZERO_BYTE;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= CIAS_ZERO_BYTE;
			rvalid <= 1'b0;
		end else begin
			rdata <= rdata_next;
			rvalid <= req.rd;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	a_div_write: assert property (wr_div |=>
		second_input_divider_low == $past(req.wdata[DIV_W-1:0]))
		else $error("divider low byte not taken");
	a_band_reserved: assert property (
		(wr_band && wband1 > CIAS_BAND_HIGHEST) |=>
		$stable(in1_band_select))
		else $error("reserved band code accepted");
	a_band_upper: assert property (wr_band |=>
		in2_band_select == (($past(wband2) <= CIAS_BAND_HIGHEST) ?
		$past(wband2) : $past(in2_band_select)))
		else $error("input two band field misplaced");
	a_active_loss: assert property (st.in2_absent |=>
		!in2_active_indicator)
		else $error("lost input shown active");
	a_active_one: assert property (!(in1_active_indicator &&
		in2_active_indicator))
		else $error("both inputs shown active");
	a_absent_read: assert property (
		(req.rd && req.addr == CIAS_OFF_ABSENT_STAT) |=>
		rdata[CIAS_BIT_IN2_ABSENT] == $past(st.in2_absent) && rvalid)
		else $error("live signal loss misread");
	a_lock_read: assert property (
		(req.rd && req.addr == CIAS_OFF_OFS_LOCK_STAT) |=>
		rdata[CIAS_BIT_UNLOCKED] == $past(st.unlocked) &&
		rdata[CIAS_BIT_HOLD_VALID] == $past(st.hold_valid))
		else $error("lock or hold status misread");
	a_hold_unrel: assert property ($fell(st.hold_valid) |=>
		hold_spec_unreliable)
		else $error("hold not flagged unreliable");
	a_sticky_set: assert property (st.in1_absent |=>
		abs_stk_reg[CIAS_BIT_IN1_ABSENT])
		else $error("sticky flag missed alarm");
	a_sticky_hold: assert property ((ofs_stk_reg[0] && !wr_ofs_stk) |=>
		ofs_stk_reg[0])
		else $error("sticky flag dropped without clear");
	a_sync_delay: assert property (status_raw.ref_absent ##1
		status_raw.ref_absent |=> st.ref_absent)
		else $error("synchroniser latency wrong");
	// Reset is sampled low on its release edge, so that attempt is skipped
	a_active_in1: assert property ((rstn && !sel2_s &&
		!st.in1_absent) |=> in1_active_indicator)
		else $error("selected input one not shown active");
	a_active_in2: assert property ((rstn && sel2_s &&
		!st.in2_absent) |=> in2_active_indicator)
		else $error("selected input two not shown active");
	a_in1_loss: assert property (st.in1_absent |=>
		!in1_active_indicator)
		else $error("lost input one shown active");
	a_in1_absent_read: assert property (
		(req.rd && req.addr == CIAS_OFF_ABSENT_STAT) |=>
		rdata[CIAS_BIT_IN1_ABSENT] == $past(st.in1_absent))
		else $error("input one signal loss misread");
	a_ref_absent_read: assert property (
		(req.rd && req.addr == CIAS_OFF_ABSENT_STAT) |=>
		rdata[CIAS_BIT_REF_ABSENT] == $past(st.ref_absent))
		else $error("reference signal loss misread");
	a_in2_offset_read: assert property (
		(req.rd && req.addr == CIAS_OFF_OFS_LOCK_STAT) |=>
		rdata[CIAS_BIT_IN2_OFFSET] == $past(st.in2_offset))
		else $error("input two offset misread");
	a_in1_offset_read: assert property (
		(req.rd && req.addr == CIAS_OFF_OFS_LOCK_STAT) |=>
		rdata[CIAS_BIT_IN1_OFFSET] == $past(st.in1_offset))
		else $error("input one offset misread");
	a_sticky_clear: assert property (
		(wr_abs_stk && !req.wdata[CIAS_BIT_REF_ABSENT] &&
		!st.ref_absent) |=> !abs_stk_reg[CIAS_BIT_REF_ABSENT])
		else $error("sticky flag not cleared by zero");
	a_div_hold: assert property (!wr_div |=>
		$stable(second_input_divider_low))
		else $error("divider low byte changed without write");

endmodule : cias_status_bank
`default_nettype wire

// [rtl/cias_pkg.sv]
// Package with register map, field layout and carrier types for the status bank
package cias_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register offsets on the device register port
	localparam logic [7:0] CIAS_OFF_IN2_DIV_LOW = 8'h30;
	localparam logic [7:0] CIAS_OFF_BAND_SEL = 8'h37;
	localparam logic [7:0] CIAS_OFF_ACTIVE_IND = 8'h80;
	localparam logic [7:0] CIAS_OFF_ABSENT_STAT = 8'h81;
	localparam logic [7:0] CIAS_OFF_OFS_LOCK_STAT = 8'h82;
	localparam logic [7:0] CIAS_OFF_ABSENT_STICKY = 8'h83;
	localparam logic [7:0] CIAS_OFF_OFS_LOCK_STICKY = 8'h84;

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0] CIAS_RST_IN2_DIV_LOW = 8'h00;
	localparam logic [2:0] CIAS_RST_BAND = 3'h0;
	localparam logic [7:0] CIAS_RST_ACTIVE_IND = 8'h20;
	localparam logic [7:0] CIAS_ZERO_BYTE = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int CIAS_BAND1_LSB = 0;
	localparam int CIAS_BAND2_LSB = 3;
	localparam int CIAS_BAND_W = 3;
	localparam int CIAS_BIT_IN1_ACTIVE = 0;
	localparam int CIAS_BIT_IN2_ACTIVE = 1;
	localparam int CIAS_BIT_REF_ABSENT = 0;
	localparam int CIAS_BIT_IN1_ABSENT = 1;
	localparam int CIAS_BIT_IN2_ABSENT = 2;
	localparam int CIAS_BIT_UNLOCKED = 0;
	localparam int CIAS_BIT_IN1_OFFSET = 1;
	localparam int CIAS_BIT_IN2_OFFSET = 2;
	localparam int CIAS_BIT_HOLD_VALID = 6;
	// Sticky layout of the offset/lock flag register is shifted up by one
	localparam int CIAS_BIT_UNLOCKED_STK = 1;
	localparam int CIAS_BIT_IN1_OFFSET_STK = 2;
	localparam int CIAS_BIT_IN2_OFFSET_STK = 3;

	////////////////////////////////////////////////////////////////////////
	// Band codes: lowest and highest legal, above that reserved
	localparam logic [2:0] CIAS_BAND_LOWEST = 3'h0;
	localparam logic [2:0] CIAS_BAND_HIGHEST = 3'h5;

	// Synchroniser depth
	localparam int CIAS_SYNC_STAGES = 2;

	////////////////////////////////////////////////////////////////////////
	// Carrier types
	typedef struct packed {
		logic hold_valid;
		logic unlocked;
		logic in2_offset;
		logic in1_offset;
		logic ref_absent;
		logic in2_absent;
		logic in1_absent;
	} cias_status_t;

	localparam int CIAS_STATUS_W = $bits(cias_status_t);

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cias_req_t;

endpackage : cias_pkg

// [rtl/cias_sync.sv]
// Multi-bit two-flop level synchroniser used for the alarm inputs
`timescale 1ns/1ps
`default_nettype none
module cias_sync #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	import cias_pkg::*;

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] q_next;

	// First stage feeds only the second stage
	always_comb begin
		meta_next = d;
		q_next = meta_reg;
	end

	// Plain registers, cleared at reset
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= meta_next;
			q <= q_next;
		end
	end

endmodule : cias_sync
`default_nettype wire

// [verification/cias_status_bank_bench.sv]
// Self-checking bench for the clock input alarm status bank
`timescale 1ns/1ps
`default_nettype none
module cias_status_bank_bench;
	import cias_pkg::*;
	logic ref_clk;
	logic rstn;
	cias_req_t req;
	cias_status_t status_raw;
	logic in2_selected;
	logic [7:0] rdata;
	logic rvalid;
	logic [7:0] div_low;
	logic [2:0] band1;
	logic [2:0] band2;
	logic act1;
	logic act2;
	logic unreliable;
	int err_total;
	int n_tests;
	logic [7:0] got;
	logic [7:0] d;
	logic [2:0] b1;
	logic [2:0] b2;
	logic [5:0] bw;

	cias_status_bank #(.DIV_W(8)) cias_status_bank_i (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.req(req),
		.status_raw(status_raw),
		.in2_selected(in2_selected),
		.rdata(rdata),
		.rvalid(rvalid),
		.second_input_divider_low(div_low),
		.in1_band_select(band1),
		.in2_band_select(band2),
		.in1_active_indicator(act1),
		.in2_active_indicator(act2),
		.hold_spec_unreliable(unreliable)
	);

	////////////////////////////////////////////////////////////////////////
	// Free-running 100 MHz clock
	initial ref_clk = 1'b0;
	always #5 ref_clk = ~ref_clk;

	// Compare and count
	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] seen);
		n_tests++;
		if (seen !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, seen);
			err_total++;
		end
	endtask : chk

	// One write strobe, outputs checked after the taking edge settles
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(posedge ref_clk);
		req.wr <= 1'b0;
		#1;
	endtask : wr

	// One read strobe; answer is looked at in its single valid cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge ref_clk);
		req.rd <= 1'b0;
		#1;
		chk("rvalid", 8'h01, {7'h00, rvalid});
		v = rdata;
	endtask : rd

	// Status needs two sync flops plus one for indicators
	task automatic settle;
		repeat (5) @(posedge ref_clk);
	endtask : settle

	function automatic logic [7:0] exp_act(cias_status_t s, logic sel);
		return 8'h20 | {6'h00, sel & !s.in2_absent, !sel & !s.in1_absent};
	endfunction : exp_act

	function automatic logic [2:0] band_next(logic [2:0] o, logic [2:0] c);
		return (c > CIAS_BAND_HIGHEST) ? o : c;
	endfunction : band_next

	task automatic wrap_up;
		$display("Checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up

	////////////////////////////////////////////////////////////////////////
	// Watchdog: the tests need about six hundred cycles, allow far more
	initial begin
		#200000;
		err_total++;
		wrap_up();
	end

	// Main sequence
	initial begin
		void'($urandom(64342));
		rstn = 1'b0;
		req = '0;
		status_raw = '0;
		in2_selected = 1'b0;
		err_total = 0;
		n_tests = 0;
		repeat (6) @(posedge ref_clk);
		chk("unreliable in reset", 8'h01, {7'h00, unreliable});
		rstn <= 1'b1;
		settle();
		rd(CIAS_OFF_ACTIVE_IND, got);
		chk("active reset", 8'h21, got);
		// Writes to read-only places change nothing, and an unmapped offset reads zero
		wr(CIAS_OFF_ACTIVE_IND, 8'hFF);
		wr(CIAS_OFF_ABSENT_STAT, 8'hFF);
		wr(CIAS_OFF_OFS_LOCK_STAT, 8'hFF);
		rd(CIAS_OFF_ACTIVE_IND, got);
		chk("active after write", 8'h21, got);
		rd(CIAS_OFF_ABSENT_STAT, got);
		chk("absent after write", 8'h00, got);
		rd(8'h55, got);
		chk("unmapped", 8'h00, got);
		$display("Test read-only done");
		for (int i = 0; i < 20; i++) begin
			d = (i == 0) ? 8'hFF : 8'($urandom);
			wr(CIAS_OFF_IN2_DIV_LOW, d);
			chk("divider port", d, div_low);
			rd(CIAS_OFF_IN2_DIV_LOW, got);
			chk("divider read", d, got);
		end
		$display("Test divider done");
		b1 = 3'h0;
		b2 = 3'h0;
		for (int i = 0; i < 24; i++) begin
			bw = (i < 8) ? {i[2:0], 3'(7 - i)} : 6'($urandom);
			wr(CIAS_OFF_BAND_SEL, {2'b11, bw});
			b1 = band_next(b1, bw[2:0]);
			b2 = band_next(b2, bw[5:3]);
			chk("band1 port", {5'h00, b1}, {5'h00, band1});
			chk("band2 port", {5'h00, b2}, {5'h00, band2});
			rd(CIAS_OFF_BAND_SEL, got);
			chk("band read", {2'b00, b2, b1}, got);
		end
		$display("Test band done");
		// Mid-run reset with quiet alarms brings back the reset values
		@(posedge ref_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk("divider reset", CIAS_RST_IN2_DIV_LOW, div_low);
		chk("band reset", {2'b00, CIAS_RST_BAND, CIAS_RST_BAND},
			{2'b00, band2, band1});
		chk("active port reset", CIAS_RST_ACTIVE_IND,
			{6'h08, act2, act1});
		chk("unreliable reset", 8'h01, {7'h00, unreliable});
		chk("rvalid reset", 8'h00, {7'h00, rvalid});
		rstn <= 1'b1;
		settle();
		rd(CIAS_OFF_BAND_SEL, got);
		chk("band after reset", {2'b00, CIAS_RST_BAND, CIAS_RST_BAND},
			got);
		rd(CIAS_OFF_IN2_DIV_LOW, got);
		chk("divider after reset", CIAS_RST_IN2_DIV_LOW, got);
		$display("Test reset done");
		for (int i = 0; i < 30; i++) begin
			@(posedge ref_clk);
			status_raw <= (i == 0) ? '1 : 7'($urandom);
			in2_selected <= (i == 1) ? 1'b1 : 1'($urandom);
			settle();
			rd(CIAS_OFF_ABSENT_STAT, got);
			chk("absent", {5'h00, status_raw.in2_absent,
				status_raw.in1_absent, status_raw.ref_absent}, got);
			rd(CIAS_OFF_OFS_LOCK_STAT, got);
			chk("offset lock", {1'b0, status_raw.hold_valid, 3'h0,
				status_raw.in2_offset, status_raw.in1_offset,
				status_raw.unlocked}, got);
			rd(CIAS_OFF_ACTIVE_IND, got);
			chk("active", exp_act(status_raw, in2_selected), got);
			chk("active ports", exp_act(status_raw, in2_selected),
				{6'h08, act2, act1});
			chk("unreliable", {7'h00, !status_raw.hold_valid},
				{7'h00, unreliable});
		end
		$display("Test status done");
		@(posedge ref_clk);
		status_raw <= '0;
		settle();
		wr(CIAS_OFF_ABSENT_STICKY, 8'h00);
		wr(CIAS_OFF_OFS_LOCK_STICKY, 8'h00);
		rd(CIAS_OFF_ABSENT_STICKY, got);
		chk("sticky cleared", 8'h00, got);
		@(posedge ref_clk);
		status_raw.ref_absent <= 1'b1;
		status_raw.unlocked <= 1'b1;
		settle();
		status_raw <= '0;
		settle();
		rd(CIAS_OFF_ABSENT_STICKY, got);
		chk("sticky absent held", 8'h01, got);
		rd(CIAS_OFF_OFS_LOCK_STICKY, got);
		chk("sticky lock held", 8'h02, got);
		wr(CIAS_OFF_ABSENT_STICKY, 8'hFE);
		wr(CIAS_OFF_OFS_LOCK_STICKY, 8'hFD);
		rd(CIAS_OFF_ABSENT_STICKY, got);
		chk("sticky absent clear", 8'h00, got);
		rd(CIAS_OFF_OFS_LOCK_STICKY, got);
		chk("sticky lock clear", 8'h00, got);
		// A live alarm outlasts a clearing write
		@(posedge ref_clk);
		status_raw.in1_absent <= 1'b1;
		settle();
		wr(CIAS_OFF_ABSENT_STICKY, 8'h00);
		rd(CIAS_OFF_ABSENT_STICKY, got);
		chk("sticky live", 8'h02, got);
		$display("Test sticky done");
		wrap_up();
	end
endmodule : cias_status_bank_bench
`default_nettype wire
